/* File: design/sctp_regs.vh */
// Constants for the sensor conditioner test port.
`ifndef SCTP_REGS_VH
`define SCTP_REGS_VH
`define SCTP_DATA_W        12
`define SCTP_ADDR_W        8
`define SCTP_INSTR_W       16
`define SCTP_CMD_W         4
`define SCTP_CMD_READ_A    4'h8
`define SCTP_CMD_READ_B    4'hA
`define SCTP_CMD_CONVERT   4'h8
`define SCTP_EOC_NS        1000
`define SCTP_CLK_NS        25
`define SCTP_EOC_CYC       ((`SCTP_EOC_NS + `SCTP_CLK_NS - 1) / `SCTP_CLK_NS)
`endif

/* File: design/sctp_sync.v */
// Two-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module sctp_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    // Clock and reset
    input  wire         clock,
    input  wire         arst_n,
    // Data
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta;

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta <= INIT;
            q    <= INIT;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // sctp_sync
`default_nettype wire

/* File: design/sctp_test_port.v */
// Test and parallel output port of the sensor conditioner.
// Operation
// - Selected only while both selects high
// - Deselected: outputs released, inputs ignored
// - Serial line used only in test mode
// - Serial line returns instruction address and data
// - Serial line released until a read command arrives
// - Monitor output carries instruction results
// - Monitor output released when test low
// - Commands accepted after reset rising edge
// - Reset ignored while test low
// - End-of-conversion pulse; falling edge latches word
// - Word is 12 bits, MSB line 11
// - Start input delays conversion, defaults high
// - Serial output enabled after command 8/A
`timescale 1ns/1ps
`default_nettype none
`include "sctp_regs.vh"
module sctp_test_port #(
    parameter DATA_W  = `SCTP_DATA_W,
    parameter ADDR_W  = `SCTP_ADDR_W,
    parameter INSTR_W = `SCTP_INSTR_W,
    parameter EOC_CYC = `SCTP_EOC_CYC
) (
    // Clock and reset
    input  wire               clock,
    input  wire               arst_n,
    // Pins from the test system
    input  wire               select_in_a,
    input  wire               select_in_b,
    input  wire               test_mode,
    input  wire               reset_pin,
    input  wire               start_pin,
    input  wire               oscillator_input,
    // Bidirectional serial line
    input  wire               serial_io_in,
    output reg                serial_io_out,
    output wire               serial_io_oe,
    // Serial monitor output
    output reg                serial_monitor_out,
    output wire               serial_monitor_oe,
    // Parallel result
    output reg  [DATA_W-1:0]  data_out,
    output wire               data_oe,
    output reg                eoc_out,
    output wire               eoc_oe,
    // Processor side
    input  wire [ADDR_W-1:0]  proc_addr,
    input  wire [INSTR_W-1:0] proc_instr,
    input  wire [INSTR_W-1:0] proc_result,
    input  wire               result_valid,
    input  wire [DATA_W-1:0]  result_word,
    output reg  [`SCTP_CMD_W-1:0] cmd_code,
    output reg                cmd_valid,
    output wire               conv_start
);
    localparam FR_W = ADDR_W + INSTR_W;
    localparam ST_IDLE = 2'd0;
    localparam ST_PULSE = 2'd1;
    localparam ST_WAIT = 2'd2;

    wire [5:0] sy;
    reg        osc_q;
    reg        rst_q;
    reg        armed;
    reg        io_en;
    reg  [2:0] bit_cnt;
    reg  [FR_W-1:0] shift_io;
    reg  [INSTR_W-1:0] shift_mon;
    reg  [1:0] state;
    reg  [15:0] eoc_cnt;

    // Selects, reset and start idle high like their pull-ups.
    sctp_sync #(.W(6), .INIT(6'h2B)) u_sync (
        .clock  (clock),
        .arst_n (arst_n),
        .d      ({start_pin, test_mode, reset_pin, serial_io_in,
                  select_in_b, select_in_a}),
        .q      (sy)
    );

    wire sel_a = sy[0];
    wire sel_b = sy[1];
    wire sdin  = sy[2];
    wire rst_s = sy[3];
    wire tst_s = sy[4];
    wire start = sy[5];
    wire osc_s;

    sctp_sync #(.W(1), .INIT(1'b0)) u_osc (
        .clock  (clock),
        .arst_n (arst_n),
        .d      (oscillator_input),
        .q      (osc_s)
    );

    wire selected = sel_a & sel_b;
    wire in_test  = selected & tst_s;
    wire osc_rise = osc_s & ~osc_q;

    // Both read codes enable the returned frame on the serial line.
    function is_read_cmd;
        input [`SCTP_CMD_W-1:0] c;
        begin
            is_read_cmd = (c == `SCTP_CMD_READ_A) ||
                          (c == `SCTP_CMD_READ_B);
        end
    endfunction

    assign serial_io_oe      = in_test & io_en;
    assign serial_monitor_oe = in_test;
    assign data_oe           = selected;
    assign eoc_oe            = selected;
    // Start is high when unconnected, so conversions run freely.
    assign conv_start        = selected & start;

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            osc_q <= 1'b0;
            rst_q <= 1'b1;
            armed <= 1'b0;
            io_en <= 1'b0;
            bit_cnt <= 3'd0;
            cmd_code <= 4'h0;
            cmd_valid <= 1'b0;
        end else begin
            osc_q <= osc_s;
            rst_q <= rst_s;
            cmd_valid <= 1'b0;
            // A deselect drops the arming and the serial output, so a unit
            // never drives the shared line until it is commanded again.
            if (!selected) begin
                io_en <= 1'b0;
                armed <= 1'b0;
                bit_cnt <= 3'd0;
            end else if (tst_s) begin
                if (rst_s & ~rst_q) begin
                    armed <= 1'b1;
                    bit_cnt <= 3'd0;
                end else if (armed & osc_rise & ~io_en) begin
                    // Commands shift in MSB first on the tester clock.
                    if (bit_cnt == 3'd3) begin
                        cmd_valid <= 1'b1;
                        if (is_read_cmd({cmd_code[2:0], sdin})) begin
                            io_en <= 1'b1;
                        end
                        bit_cnt <= 3'd0;
                    end else begin
                        bit_cnt <= bit_cnt + 3'd1;
                    end
                    cmd_code <= {cmd_code[2:0], sdin};
                end
            end
            // Reset pin changes without test mode are not acted upon.
        end
    end

    // Returned frames: address then instruction on the serial line, result on the monitor, MSB first.
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            shift_io <= {FR_W{1'b0}};
            shift_mon <= {INSTR_W{1'b0}};
            serial_io_out <= 1'b0;
            serial_monitor_out <= 1'b0;
        end else if (in_test) begin
            if (result_valid) begin
                // A result is a single-cycle strobe, so it loads the
                // frames at once instead of waiting for a tester edge.
                shift_io <= {proc_addr, proc_instr};
                shift_mon <= proc_result;
            end else if (osc_rise) begin
                if (io_en) begin
                    serial_io_out <= shift_io[FR_W-1];
                    shift_io <= {shift_io[FR_W-2:0], 1'b0};
                end
                serial_monitor_out <= shift_mon[INSTR_W-1];
                shift_mon <= {shift_mon[INSTR_W-2:0], 1'b0};
            end
        end
    end

    // Word loads first, then the strobe rises, so the falling edge
    // always finds settled data.
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            eoc_out <= 1'b0;
            eoc_cnt <= 16'h0000;
            data_out <= {DATA_W{1'b0}};
        end else begin
            case (state)
            ST_IDLE: begin
                if (result_valid) begin
                    data_out <= result_word;
                    state <= ST_PULSE;
                end
            end
            ST_PULSE: begin
                eoc_out <= 1'b1;
                eoc_cnt <= 16'h0001;
                state <= ST_WAIT;
            end
            ST_WAIT: begin
                // A result that arrives during the pulse is dropped, which
                // keeps the word steady for whoever captures on the fall.
                if (eoc_cnt >= EOC_CYC[15:0]) begin
                    eoc_out <= 1'b0;
                    state <= ST_IDLE;
                end else begin
                    eoc_cnt <= eoc_cnt + 16'h0001;
                end
            end
            default: state <= ST_IDLE;
            endcase
        end
    end
endmodule // sctp_test_port
`default_nettype wire

/* File: verif/sctp_tester.sv */
// Test-system model: gated link clock and serial command bits.
`timescale 1ns/1ps
`default_nettype none
module sctp_tester (
    // Tester pins
    output logic osc,
    output logic sd_en,
    output logic sd
);
    initial begin
        osc = 1'b0;
        sd_en = 1'b0;
        sd = 1'b0;
    end
    // The link clock stands still between frames.
    task automatic send(input logic [3:0] c);
        for (int i = 3; i >= 0; i--) begin
            sd_en = 1'b1;
            sd = c[i];
            #50 osc = 1'b1;
            #100 osc = 1'b0;
            #50;
        end
        sd_en = 1'b0;
    endtask
    // Clock out returned bits while the line is left to the device.
    task automatic clk(input int n);
        for (int i = 0; i < n; i++) begin
            #50 osc = 1'b1;
            #100 osc = 1'b0;
            #50;
        end
    endtask
endmodule // sctp_tester
`default_nettype wire

/* File: verif/sctp_test_port_monitor.sv */
// Pin-level checks on the test port.
`timescale 1ns/1ps
`default_nettype none
`include "sctp_regs.vh"
module sctp_test_port_monitor (
    // Clock, reset and pins
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic        select_in_a,
    input wire logic        select_in_b,
    input wire logic        test_mode,
    // Outputs
    input wire logic        data_oe,
    input wire logic        eoc_oe,
    input wire logic        eoc_out,
    input wire logic [11:0] data_out,
    input wire logic        serial_io_oe,
    input wire logic        serial_monitor_oe,
    // Processor side
    input wire logic        result_valid,
    input wire logic [11:0] result_word,
    input wire logic        cmd_valid,
    input wire logic [3:0]  cmd_code
);
    logic [2:0] up;
    // Synchronisers reset to selected, so pin checks wait a few cycles.
    always_ff @(posedge clock or negedge arst_n)
        if (!arst_n)
            up <= 3'h0;
        else if (up != 3'h7)
            up <= up + 3'h1;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    AST_DESEL_A: assert property (
        (up == 3'h7 && !select_in_a) [*3] |-> !data_oe && !eoc_oe)
        else $error("outputs driven while deselected");
    AST_DESEL_B: assert property (
        (up == 3'h7 && !select_in_b) [*3] |-> !serial_io_oe && !data_oe)
        else $error("serial line driven while deselected");
    AST_TEST_LOW: assert property (
        (up == 3'h7 && !test_mode) [*3] |-> !serial_monitor_oe)
        else $error("monitor driven outside test mode");
    AST_MON_SEL: assert property (serial_monitor_oe |-> data_oe)
        else $error("monitor driven while deselected");
    AST_IO_GATE: assert property (serial_io_oe |-> serial_monitor_oe)
        else $error("serial line driven outside test mode");
    AST_EOC_LEN: assert property ($rose(eoc_out) |-> ##39 eoc_out ##1 !eoc_out)
        else $error("end pulse length wrong");
    AST_WORD_HOLD: assert property (eoc_out |-> $stable(data_out))
        else $error("word moved during end pulse");
    AST_WORD: assert property (
        result_valid |=> data_out == $past(result_word) ##1 $rose(eoc_out))
        else $error("word or end pulse missing");
    AST_CMD_OE: assert property (cmd_valid && serial_monitor_oe &&
        (cmd_code == `SCTP_CMD_READ_A || cmd_code == `SCTP_CMD_READ_B)
        |-> ##[0:1] serial_io_oe) else $error("serial output not enabled");
    cover property ($fell(eoc_out));
    cover property ($rose(serial_io_oe));
    cover property ($fell(data_oe));
endmodule // sctp_test_port_monitor
bind sctp_test_port sctp_test_port_monitor mon (.clock(clock),
    .arst_n(arst_n), .select_in_a(select_in_a), .select_in_b(select_in_b),
    .test_mode(test_mode), .data_oe(data_oe), .eoc_oe(eoc_oe),
    .eoc_out(eoc_out), .data_out(data_out), .serial_io_oe(serial_io_oe),
    .serial_monitor_oe(serial_monitor_oe), .result_valid(result_valid),
    .result_word(result_word), .cmd_valid(cmd_valid), .cmd_code(cmd_code));
`default_nettype wire

/* File: verif/sctp_test_port_tb.sv */
// Self-checking bench for the sensor conditioner test port.
`timescale 1ns/1ps
`default_nettype none
`include "sctp_regs.vh"
`define CHK(n, e, g) chk(n, e, g)
module sctp_test_port_tb;
    logic        clock, arst_n, sel_a, sel_b, test_mode, reset_pin, got;
    logic        start_pin, result_valid, io_out, io_oe, mon, mon_oe;
    logic        data_oe, eoc, eoc_oe, cmd_valid, conv_start, osc, sd_en, sd;
    logic [11:0] result_word, data_out;
    logic [3:0]  cmd_code, got_cmd;
    logic [23:0] fr;
    logic [15:0] mr;
    int          fails = 0, n_tests = 0;
    logic [11:0] rows [4] = '{12'h000, 12'hFFF, 12'hA5C, 12'h801};
    // The serial line has a pull-down when nobody drives it.
    wire io_in = io_oe ? io_out : (sd_en ? sd : 1'b0);
    sctp_tester tst (.osc(osc), .sd_en(sd_en), .sd(sd));
    sctp_test_port uut (.clock(clock), .arst_n(arst_n), .select_in_a(sel_a),
        .select_in_b(sel_b), .test_mode(test_mode), .reset_pin(reset_pin),
        .start_pin(start_pin), .oscillator_input(osc), .serial_io_in(io_in),
        .serial_io_out(io_out), .serial_io_oe(io_oe),
        .serial_monitor_out(mon), .serial_monitor_oe(mon_oe),
        .data_out(data_out), .data_oe(data_oe), .eoc_out(eoc),
        .eoc_oe(eoc_oe), .proc_addr(8'h5A), .proc_instr(16'h1234),
        .proc_result(16'hC3C3), .result_valid(result_valid),
        .result_word(result_word), .cmd_code(cmd_code),
        .cmd_valid(cmd_valid), .conv_start(conv_start));
    always @(posedge clock)
        if (cmd_valid === 1'b1) begin
            got <= 1'b1;
            got_cmd <= cmd_code;
        end
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    task automatic conv(logic [11:0] w);
        int k;
        result_word = w;
        result_valid = 1'b1;
        cyc(1);
        result_valid = 1'b0;
        for (k = 0; k < 50 && eoc !== 1'b1; k++) cyc(1);
        if (eoc !== 1'b1) begin
            `CHK("eoc rise", 1'b1, eoc);
            wrap_up;
        end
        for (k = 0; k < 50 && eoc === 1'b1; k++) cyc(1);
        `CHK("eoc high cycles", 12'd40, k);
        `CHK("word at eoc fall", w, data_out);
        $display("done: conversion %h", w);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        {arst_n, test_mode, reset_pin, result_valid, got} = 5'h00;
        {sel_a, sel_b, start_pin} = 3'h7;
        result_word = 12'h000;
        cyc(4);
        arst_n = 1'b1;
        cyc(3);
        foreach (rows[i]) conv(rows[i]);
        start_pin = 1'b0;
        cyc(3);
        `CHK("start low", 1'b0, conv_start);
        `CHK("monitor oe test low", 1'b0, mon_oe);
        start_pin = 1'b1;
        reset_pin = 1'b1;
        cyc(3);
        `CHK("start high", 1'b1, conv_start);
        $display("done: start input");
        reset_pin = 1'b0;
        test_mode = 1'b1;
        cyc(3);
        tst.send(`SCTP_CMD_READ_A);
        cyc(2);
        `CHK("command unarmed", 1'b0, got);
        `CHK("monitor oe test high", 1'b1, mon_oe);
        reset_pin = 1'b1;
        cyc(3);
        tst.send(`SCTP_CMD_READ_B);
        cyc(2);
        `CHK("command armed", 1'b1, got);
        `CHK("command code", 4'hA, got_cmd);
        `CHK("serial oe", 1'b1, io_oe);
        $display("done: command path");
        conv(12'h3C6);
        fr = 24'h00_0000;
        mr = 16'h0000;
        for (int i = 0; i < 24; i++) begin
            tst.clk(1);
            fr = {fr[22:0], io_in};
            if (i < 16) mr = {mr[14:0], mon};
        end
        `CHK("returned frame", 32'h005A_1234, fr);
        `CHK("monitor frame", 32'h0000_C3C3, mr);
        $display("done: returned frames");
        {sel_a, sel_b} = 2'h0;
        cyc(3);
        `CHK("outputs released", 4'h0, {data_oe, eoc_oe, io_oe, mon_oe});
        $display("done: deselect");
        wrap_up;
    end
endmodule // sctp_test_port_tb
`default_nettype wire
